/* File: verilog/ovrs_top.sv */
`include "ovrs_map.svh"
`default_nettype none
module ovrs_top #(
    parameter int CNT_W = 21,
    parameter int PWR_CYC_0 =
        int'(`OVRS_T_PWR0_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int PWR_CYC_1 =
        int'(`OVRS_T_PWR1_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int PWR_CYC_2 =
        int'(`OVRS_T_PWR2_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int PWR_CYC_3 =
        int'(`OVRS_T_PWR3_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int FLT_CYC_0 =
        int'(`OVRS_T_FLT0_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int FLT_CYC_1 =
        int'(`OVRS_T_FLT1_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int FLT_CYC_2 =
        int'(`OVRS_T_FLT2_MS * 1000.0 * `OVRS_CLK_MHZ),
    parameter int FLT_CYC_3 =
        int'(`OVRS_T_FLT3_MS * 1000.0 * `OVRS_CLK_MHZ)
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic turn_on,
    input wire logic supply_ok,
    input wire logic soft_start_done,
    input wire logic [`OVRS_CODE_W-1:0] delay_select_pin,
    input wire logic [`OVRS_LVL_W-1:0] sensed_output_level,
    input wire logic supply_ok_out_in,
    output logic supply_ok_out,
    output logic supply_ok_out_oe_b
);

    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------

    typedef struct packed {
        ovrs_pkg::ovrs_state_t st;
        logic [CNT_W-1:0] cnt;
        logic rel;
    } ovrs_top_st_t;

    ovrs_top_st_t q;
    ovrs_top_st_t next_q;

    logic active;
    logic [`OVRS_LVL_W-1:0] low_trip_level;
    logic [`OVRS_LVL_W-1:0] high_trip_level;
    logic recovered;
    logic fault_hit;
    logic [CNT_W-1:0] pwr_lim;
    logic [CNT_W-1:0] flt_lim;

    ovrs_mon_if mon ();

    // -----------------------------------------------------------
    // Delay selection and glitch filter
    // -----------------------------------------------------------

    ovrs_select u_select (
        .clock (clock),
        .rst_b (rst_b),
        .mon (mon.sel)
    );

    ovrs_filter u_filter (
        .clock (clock),
        .rst_b (rst_b),
        .mon (mon.flt)
    );

    assign mon.code = delay_select_pin;
    assign mon.sample = (q.st == ovrs_pkg::OVRS_INIT);
    assign mon.clear = (q.st == ovrs_pkg::OVRS_OFF);

    // -----------------------------------------------------------
    // Trip comparison
    // -----------------------------------------------------------

    assign high_trip_level = `OVRS_OV_TRIP;

    always_comb begin
        case (mon.cfg.uv)
            2'h0: low_trip_level = `OVRS_UV_8;
            2'h1: low_trip_level = `OVRS_UV_14;
            2'h2: low_trip_level = `OVRS_UV_25;
            default: low_trip_level = `OVRS_UV_40;
        endcase
    end

    assign mon.raw = {sensed_output_level > high_trip_level,
        sensed_output_level < low_trip_level};
    assign fault_hit = mon.hit != 2'h0;

    // Release needs the level back inside the window narrowed by
    // hysteresis, so a level hovering at a trip cannot chatter.
    assign recovered =
        (sensed_output_level > `OVRS_LVL_W'(low_trip_level
            + `OVRS_HYS)) &&
        (sensed_output_level < `OVRS_LVL_W'(high_trip_level
            - `OVRS_HYS));

    // -----------------------------------------------------------
    // Delay limits
    // -----------------------------------------------------------

    always_comb begin
        case (mon.cfg.dly)
            ovrs_pkg::OVRS_DLY_0: begin
                pwr_lim = CNT_W'(PWR_CYC_0 - 1);
                flt_lim = CNT_W'(FLT_CYC_0 - 1);
            end
            ovrs_pkg::OVRS_DLY_1: begin
                pwr_lim = CNT_W'(PWR_CYC_1 - 1);
                flt_lim = CNT_W'(FLT_CYC_1 - 1);
            end
            ovrs_pkg::OVRS_DLY_2: begin
                pwr_lim = CNT_W'(PWR_CYC_2 - 1);
                flt_lim = CNT_W'(FLT_CYC_2 - 1);
            end
            default: begin
                pwr_lim = CNT_W'(PWR_CYC_3 - 1);
                flt_lim = CNT_W'(FLT_CYC_3 - 1);
            end
        endcase
    end

    // -----------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------

    assign active = turn_on && supply_ok;

    always_comb begin
        next_q = q;
        next_q.cnt = CNT_W'(q.cnt + 1'h1);
        if (!active) begin
            next_q.st = ovrs_pkg::OVRS_OFF;
        end else begin
            case (q.st)
                ovrs_pkg::OVRS_OFF: begin
                    next_q.st = ovrs_pkg::OVRS_INIT;
                end
                ovrs_pkg::OVRS_INIT: begin
                    if (mon.cfg_valid) begin
                        next_q.st = ovrs_pkg::OVRS_SOFT;
                    end
                end
                ovrs_pkg::OVRS_SOFT: begin
                    if (soft_start_done) begin
                        next_q.st = ovrs_pkg::OVRS_PWR_DLY;
                        next_q.cnt = '0;
                    end
                end
                ovrs_pkg::OVRS_PWR_DLY: begin
                    // A fault already filtered at the end of the delay
                    // skips the release, so the pin never blips high.
                    if (q.cnt == pwr_lim && fault_hit) begin
                        next_q.st = ovrs_pkg::OVRS_FAULT;
                    end else if (q.cnt == pwr_lim) begin
                        next_q.st = ovrs_pkg::OVRS_RUN;
                    end
                end
                ovrs_pkg::OVRS_RUN: begin
                    if (fault_hit) begin
                        next_q.st = ovrs_pkg::OVRS_FAULT;
                    end
                end
                ovrs_pkg::OVRS_FAULT: begin
                    if (recovered && !fault_hit) begin
                        next_q.st = ovrs_pkg::OVRS_FLT_DLY;
                        next_q.cnt = '0;
                    end
                end
                ovrs_pkg::OVRS_FLT_DLY: begin
                    if (fault_hit) begin
                        next_q.st = ovrs_pkg::OVRS_FAULT;
                    end else if (q.cnt == flt_lim) begin
                        next_q.st = ovrs_pkg::OVRS_RUN;
                    end
                end
                default: begin
                    next_q.st = ovrs_pkg::OVRS_OFF;
                end
            endcase
        end
        // The counter only matters in the two delay states; it
        // is parked at zero elsewhere so a stale count never leaks.
        if (next_q.st != ovrs_pkg::OVRS_PWR_DLY &&
            next_q.st != ovrs_pkg::OVRS_FLT_DLY) begin
            next_q.cnt = '0;
        end
        next_q.rel = (next_q.st == ovrs_pkg::OVRS_RUN);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // -----------------------------------------------------------
    // Open-drain reset pin
    // -----------------------------------------------------------

    // The pin is never driven high; the pull-up makes the high.
    assign supply_ok_out = 1'h0;
    assign supply_ok_out_oe_b = q.rel;

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------

    hold_low_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.st inside {ovrs_pkg::OVRS_OFF, ovrs_pkg::OVRS_INIT,
            ovrs_pkg::OVRS_SOFT, ovrs_pkg::OVRS_PWR_DLY}
        |-> !supply_ok_out_oe_b)
        else $error("Reset released before startup delay ended.");

    start_release_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(supply_ok_out_oe_b)
        && $past(q.st) == ovrs_pkg::OVRS_PWR_DLY
        |-> $past(q.cnt) == pwr_lim)
        else $error("Startup release at wrong count.");

    fault_release_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(supply_ok_out_oe_b)
        && $past(q.st) != ovrs_pkg::OVRS_PWR_DLY
        |-> $past(q.st) == ovrs_pkg::OVRS_FLT_DLY
        && $past(q.cnt) == flt_lim)
        else $error("Fault release without full delay.");

    fault_drop_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        supply_ok_out_oe_b && fault_hit |=> !supply_ok_out_oe_b)
        else $error("Filtered fault did not pull reset low.");

    refault_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.st == ovrs_pkg::OVRS_FLT_DLY && fault_hit && active
        |=> q.st == ovrs_pkg::OVRS_FAULT && q.cnt == '0)
        else $error("New fault did not cancel pending release.");

    turn_off_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        !turn_on |=> q.st == ovrs_pkg::OVRS_OFF
        && !supply_ok_out_oe_b)
        else $error("Turn-off did not force reset low.");

    supply_low_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        !supply_ok |=> !supply_ok_out_oe_b ##1 !supply_ok_out_oe_b)
        else $error("Low supply did not hold reset low.");

    pin_low_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        !supply_ok_out_oe_b |-> supply_ok_out == 1'h0)
        else $error("Reset pin driven to a high level.");

    in_range_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        supply_ok_out_oe_b |-> $past(mon.hit) == 2'h0)
        else $error("Reset released while a fault was flagged.");

    uv_flag_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.st == ovrs_pkg::OVRS_RUN && mon.hit[0] |=> q.st inside
        {ovrs_pkg::OVRS_FAULT, ovrs_pkg::OVRS_OFF})
        else $error("Low trip fault did not leave the run state.");

    recover_wait_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.st == ovrs_pkg::OVRS_FAULT && !recovered
        |=> q.st != ovrs_pkg::OVRS_FLT_DLY)
        else $error("Fault release started outside the window.");

    trip_frozen_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        mon.cfg_valid && $past(mon.cfg_valid) |-> $stable(low_trip_level))
        else $error("Low trip level moved after initialization.");

    open_pin_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(mon.cfg_valid) && $past(delay_select_pin) > `OVRS_CODE_150K
        |-> mon.cfg.dly == ovrs_pkg::OVRS_DLY_2 && mon.cfg.uv == 2'h0)
        else $error("Open delay pin gave the wrong selection.");

    short_code_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(mon.cfg_valid) && $past(delay_select_pin) < `OVRS_CODE_MID
        |-> mon.cfg.dly == ovrs_pkg::OVRS_DLY_0
        && mon.cfg.uv == $past(delay_select_pin[1:0]))
        else $error("Low resistor code gave the wrong selection.");

    long_code_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        $rose(mon.cfg_valid) && $past(delay_select_pin) == `OVRS_CODE_100K
        |-> mon.cfg.dly == ovrs_pkg::OVRS_DLY_3 && mon.cfg.uv == 2'h0)
        else $error("Longest delay code gave the wrong selection.");

    pwr_count_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.st == ovrs_pkg::OVRS_PWR_DLY |-> q.cnt <= pwr_lim)
        else $error("Startup delay counter ran past its limit.");

    flt_count_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.st == ovrs_pkg::OVRS_FLT_DLY |-> q.cnt <= flt_lim)
        else $error("Fault delay counter ran past its limit.");
endmodule // ovrs_top
`default_nettype wire

/* File: verilog/ovrs_map.svh */
// Contract
// - Reset pin released only while level in range
// - Startup delay after soft-start, then release
// - Level below low trip pulls reset low
// - Low fault releases after hysteresis and delay
// - Level above high trip pulls reset low
// - High fault releases after hysteresis and delay
// - Fault acts only after blanking time
// - Short excursions leave reset released
// - Delay select sampled once at initialization
// - High trip level is fixed
// - Mid resistor codes give medium delays
// - Low resistor codes give shortest delays
// - Open pin gives 7.7/5.1 ms, -8 %
// - Supervision works while supply stays sufficient
// - Reset pin only pulls low or releases
// - Turn-on high activates, low keeps off
`ifndef OVRS_MAP_SVH
`define OVRS_MAP_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define OVRS_CLK_MHZ 100
`define OVRS_T_BLANK_US 5
`define OVRS_T_PWR0_MS 0.06
`define OVRS_T_PWR1_MS 1.9
`define OVRS_T_PWR2_MS 7.7
`define OVRS_T_PWR3_MS 15.4
`define OVRS_T_FLT0_MS 0.03
`define OVRS_T_FLT1_MS 1.3
`define OVRS_T_FLT2_MS 5.1
`define OVRS_T_FLT3_MS 10.2

// ---------------------------------------------------------------
// Levels in tenths of a percent of nominal feedback
// ---------------------------------------------------------------
`define OVRS_LVL_W 11
`define OVRS_UV_8 11'h398
`define OVRS_UV_14 11'h35C
`define OVRS_UV_25 11'h2EE
`define OVRS_UV_40 11'h258
`define OVRS_OV_TRIP 11'h42E
`define OVRS_HYS 11'h00A

// ---------------------------------------------------------------
// Delay-select resistor codes
// ---------------------------------------------------------------
`define OVRS_CODE_W 4
`define OVRS_CODE_MID 4'h4
`define OVRS_CODE_LONG 4'h8
`define OVRS_CODE_100K 4'hB
`define OVRS_CODE_150K 4'hC

`endif

/* File: verilog/ovrs_pkg.sv */
`default_nettype none
package ovrs_pkg;
    typedef enum logic [2:0] {
        OVRS_OFF = 3'h0,
        OVRS_INIT = 3'h1,
        OVRS_SOFT = 3'h2,
        OVRS_PWR_DLY = 3'h3,
        OVRS_RUN = 3'h4,
        OVRS_FAULT = 3'h5,
        OVRS_FLT_DLY = 3'h6
    } ovrs_state_t;

    typedef enum logic [1:0] {
        OVRS_DLY_0 = 2'h0,
        OVRS_DLY_1 = 2'h1,
        OVRS_DLY_2 = 2'h2,
        OVRS_DLY_3 = 2'h3
    } ovrs_dly_t;

    typedef struct packed {
        ovrs_dly_t dly;
        logic [1:0] uv;
    } ovrs_cfg_t;
endpackage
`default_nettype wire

/* File: verilog/ovrs_mon_if.sv */
`default_nettype none
interface ovrs_mon_if;
    logic sample;
    logic clear;
    logic [3:0] code;
    ovrs_pkg::ovrs_cfg_t cfg;
    logic cfg_valid;
    logic [1:0] raw;
    logic [1:0] hit;

    modport sel (input sample, input clear, input code,
        output cfg, output cfg_valid);
    modport flt (input raw, input clear, output hit);
    modport ctl (output sample, output clear, output code,
        output raw, input cfg, input cfg_valid, input hit);
endinterface
`default_nettype wire

/* File: verilog/ovrs_select.sv */
`include "ovrs_map.svh"
`default_nettype none
module ovrs_select (
    input wire logic clock,
    input wire logic rst_b,
    ovrs_mon_if.sel mon
);
    typedef struct packed {
        logic done;
        ovrs_pkg::ovrs_cfg_t cfg;
    } ovrs_sel_st_t;

    ovrs_sel_st_t q;
    ovrs_sel_st_t next_q;
    ovrs_pkg::ovrs_cfg_t dec;

    always_comb begin
        dec.uv = mon.code[1:0];
        dec.dly = ovrs_pkg::OVRS_DLY_2;
        if (mon.code < `OVRS_CODE_MID) begin
            dec.dly = ovrs_pkg::OVRS_DLY_0;
        end else if (mon.code < `OVRS_CODE_LONG) begin
            dec.dly = ovrs_pkg::OVRS_DLY_1;
        end else if (mon.code < `OVRS_CODE_100K) begin
            dec.uv = 2'(mon.code[1:0] + 2'h1);
        end else if (mon.code <= `OVRS_CODE_150K) begin
            dec.dly = ovrs_pkg::OVRS_DLY_3;
            dec.uv = {1'h0, ~mon.code[0]};
        end else begin
            dec.uv = 2'h0;
        end
    end

    // The choice is frozen until the block is switched off again.
    always_comb begin
        next_q = q;
        if (mon.clear) begin
            next_q.done = 1'h0;
        end else if (mon.sample && !q.done) begin
            next_q.done = 1'h1;
            next_q.cfg = dec;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign mon.cfg = q.cfg;
    assign mon.cfg_valid = q.done;

    cfg_hold_a: assert property (
        @(posedge clock) disable iff (!rst_b)
        q.done && $past(q.done) |-> $stable(q.cfg))
        else $error("Delay selection changed after initialization.");
endmodule // ovrs_select
`default_nettype wire

/* File: verilog/ovrs_filter.sv */
`include "ovrs_map.svh"
`default_nettype none
module ovrs_filter (
    input wire logic clock,
    input wire logic rst_b,
    ovrs_mon_if.flt mon
);
    localparam int BLANK = `OVRS_T_BLANK_US * `OVRS_CLK_MHZ;
    localparam int BW = $clog2(BLANK + 1);

    typedef struct packed {
        logic [1:0][BW-1:0] cnt;
        logic [1:0] hit;
    } ovrs_flt_st_t;

    ovrs_flt_st_t q;
    ovrs_flt_st_t next_q;

    // Channel 0 watches the low trip, channel 1 the high trip.
    always_comb begin
        next_q = q;
        for (int i = 0; i < 2; i++) begin
            if (!mon.raw[i] || mon.clear) begin
                next_q.cnt[i] = '0;
                next_q.hit[i] = 1'h0;
            end else if (q.cnt[i] == BW'(BLANK)) begin
                next_q.hit[i] = 1'h1;
            end else begin
                next_q.cnt[i] = BW'(q.cnt[i] + 1'h1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign mon.hit = q.hit;

    for (genvar g = 0; g < 2; g++) begin : g_chk
        blank_hold_a: assert property (
            @(posedge clock) disable iff (!rst_b)
            $rose(q.hit[g]) |-> $past(q.cnt[g]) == BW'(BLANK))
            else $error("Fault flagged before the blanking time.");
        short_drop_a: assert property (
            @(posedge clock) disable iff (!rst_b)
            !mon.raw[g] |=> !q.hit[g])
            else $error("Fault flag outlived its excursion.");
    end
endmodule // ovrs_filter
`default_nettype wire

/* File: verif/ovrs_mcu_model.sv */
`default_nettype none
module ovrs_mcu_model (
    input wire logic oe_b,
    input wire logic drive,
    output logic pin_level,
    output logic [15:0] resets
);
    timeunit 1ns;
    timeprecision 100ps;
    // The model drives a released pin high itself, standing in for
    // the pull-up resistor on the board.
    assign pin_level = oe_b ? 1'b1 : drive;
    initial resets = 16'h0000;
    // Every falling edge of the pin would reset the microcontroller.
    always @(negedge pin_level) begin
        resets <= resets + 16'h0001;
    end
endmodule // ovrs_mcu_model
`default_nettype wire

/* File: verif/output_voltage_reset_supervisor_tb_top.sv */
`include "ovrs_map.svh"
`default_nettype none
module output_voltage_reset_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED at %0t: got %0d want %0d", $time, a, b); end end
    localparam int PWR [4] = '{40, 60, 80, 100};
    localparam int FLT [4] = '{20, 30, 50, 700};
    localparam int BLANK = `OVRS_T_BLANK_US * `OVRS_CLK_MHZ;
    logic clock;
    logic rst_b;
    logic turn_on;
    logic supply_ok;
    logic soft_start_done;
    logic [`OVRS_CODE_W-1:0] delay_select_pin;
    logic [`OVRS_LVL_W-1:0] sensed_output_level;
    logic pin_level;
    logic supply_ok_out;
    logic supply_ok_out_oe_b;
    logic [15:0] resets;
    logic [15:0] lfsr;
    int mismatches;
    int checks;
    int cycles;

    ovrs_top #(
        .PWR_CYC_0(PWR[0]), .PWR_CYC_1(PWR[1]),
        .PWR_CYC_2(PWR[2]), .PWR_CYC_3(PWR[3]),
        .FLT_CYC_0(FLT[0]), .FLT_CYC_1(FLT[1]),
        .FLT_CYC_2(FLT[2]), .FLT_CYC_3(FLT[3])
    ) dut (
        .clock(clock),
        .rst_b(rst_b),
        .turn_on(turn_on),
        .supply_ok(supply_ok),
        .soft_start_done(soft_start_done),
        .delay_select_pin(delay_select_pin),
        .sensed_output_level(sensed_output_level),
        .supply_ok_out_in(pin_level),
        .supply_ok_out(supply_ok_out),
        .supply_ok_out_oe_b(supply_ok_out_oe_b)
    );

    ovrs_mcu_model mcu (
        .oe_b(supply_ok_out_oe_b),
        .drive(supply_ok_out),
        .pin_level(pin_level),
        .resets(resets)
    );

    always #5 clock = ~clock;

    // ----------------------------------------
    // Reference model of the resistor decode
    // ----------------------------------------
    function automatic int m_idx(int c);
        if (c < 4) return 0;
        if (c < 8) return 1;
        if (c < 11 || c > 12) return 2;
        return 3;
    endfunction

    function automatic int m_trip(int c);
        int t [16] = '{920, 860, 750, 600, 920, 860, 750, 600,
            860, 750, 600, 920, 860, 920, 920, 920};
        return t[c];
    endfunction

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // A random level that stays inside the window for every setting.
    function automatic int calm();
        lfsr = lfsr_next(lfsr);
        return 940 + int'(lfsr % 16'h006E);
    endfunction

    // ----------------------------------------
    // Drivers and scenarios
    // ----------------------------------------
    task automatic set_lvl(int v);
        @(posedge clock);
        sensed_output_level <= v[10:0];
    endtask

    task automatic stay(int len, logic v, output int bad);
        bad = 0;
        repeat (len) begin
            @(posedge clock);
            #1;
            if (supply_ok_out_oe_b !== v) bad++;
        end
    endtask

    task automatic wait_oe(logic v, int lim, output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (supply_ok_out_oe_b !== v && n < lim);
    endtask

    task automatic power_up(int c);
        int n;
        int bad;
        @(posedge clock);
        delay_select_pin <= c[3:0];
        turn_on <= 1'b1;
        supply_ok <= 1'b1;
        soft_start_done <= 1'b0;
        sensed_output_level <= 11'h000;
        stay(20, 1'b0, bad);
        `CHK(bad, 0)
        @(posedge clock);
        soft_start_done <= 1'b1;
        sensed_output_level <= 11'h3E8;
        wait_oe(1'b1, PWR[m_idx(c)] + 10, n);
        `CHK(n, PWR[m_idx(c)] + 1)
    endtask

    task automatic no_trip(int lvl, int len);
        int bad;
        int r0;
        r0 = int'(resets);
        set_lvl(lvl);
        stay(len, 1'b1, bad);
        set_lvl(calm());
        `CHK(bad, 0)
        `CHK(int'(resets), r0)
    endtask

    task automatic fault(int bad_lvl, int hys_lvl, int f);
        int n;
        int bad;
        int r0;
        r0 = int'(resets);
        set_lvl(bad_lvl);
        wait_oe(1'b0, BLANK + 200, n);
        `CHK(n, BLANK + 2)
        `CHK(pin_level, 1'b0)
        `CHK(int'(resets), r0 + 1)
        set_lvl(hys_lvl);
        stay(f + 100, 1'b0, bad);
        `CHK(bad, 0)
        set_lvl(calm());
        wait_oe(1'b1, f + 10, n);
        `CHK(n inside {[f + 1:f + 4]}, 1'b1)
    endtask

    task automatic refault(int c, int f);
        int n;
        int bad;
        int b2;
        set_lvl(m_trip(c) - 1);
        wait_oe(1'b0, BLANK + 200, n);
        set_lvl(calm());
        stay(150, 1'b0, bad);
        set_lvl(m_trip(c) - 1);
        stay(600, 1'b0, b2);
        set_lvl(calm());
        wait_oe(1'b1, f + 10, n);
        `CHK(bad + b2, 0)
        `CHK(n inside {[f + 1:f + 4]}, 1'b1)
    endtask

    task automatic power_off(int c);
        int n;
        int bad;
        @(posedge clock);
        if (c[0]) begin
            supply_ok <= 1'b0;
        end else begin
            turn_on <= 1'b0;
        end
        wait_oe(1'b0, 4, n);
        `CHK(n inside {[1:2]}, 1'b1)
        stay(30, 1'b0, bad);
        `CHK(bad, 0)
    endtask

    task automatic run_code(int c);
        int f;
        f = FLT[m_idx(c)];
        power_up(c);
        // Moving the pin after start-up must not change anything.
        @(posedge clock);
        delay_select_pin <= lfsr[3:0];
        no_trip(m_trip(c) - 5, 400);
        no_trip(1080, 400);
        no_trip(m_trip(c), 600);
        no_trip(1070, 600);
        fault(m_trip(c) - 1, m_trip(c) + 5, f);
        fault(1071, 1065, f);
        if (m_idx(c) == 3) refault(c, f);
        power_off(c);
        $display("test for code %0d finished", c);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        turn_on = 1'b0;
        supply_ok = 1'b0;
        soft_start_done = 1'b0;
        delay_select_pin = 4'h0;
        sensed_output_level = 11'h3E8;
        lfsr = 16'h75D1;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        repeat (4) @(posedge clock);
        #1;
        `CHK(supply_ok_out_oe_b, 1'b0)
        @(posedge clock);
        rst_b <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            run_code(c);
        end
        stop_test();
    end
endmodule // output_voltage_reset_supervisor_tb_top
`default_nettype wire
